// [sim/sep_link_chk.sv]
// Checker for the two-wire link between the EEPROM slave and its master.
`timescale 1ns/100ps
`default_nettype none

module sep_link_chk #(
	parameter int PROG_CYCLES = 2000
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic O_BUSY,
	input wire logic scl,
	input wire logic sda,
	input wire logic wp,
	input wire logic dev_sda_oe
);
	logic        scl_q;
	logic        sda_q;
	logic        in_frame;
	logic [7:0]  since_stop;
	logic [31:0] busy_cnt;
	wire         start_seen = scl_q & scl & sda_q & ~sda;
	wire         stop_seen  = scl_q & scl & ~sda_q & sda;

	// ========
	// Frame tracking
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			in_frame   <= 1'b0;
			since_stop <= 8'hff;
			busy_cnt   <= 32'h0;
		end
		else
		begin
			scl_q      <= scl;
			sda_q      <= sda;
			in_frame   <= start_seen | (in_frame & ~stop_seen);
			since_stop <= stop_seen ? 8'h00 : since_stop + {7'h00, since_stop != 8'hff};
			busy_cnt   <= O_BUSY ? busy_cnt + 32'h1 : 32'h0;
		end
	end

	// ========
	// Properties
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	sequence scl_low_hold;
		!scl [*6];
	endsequence

	chk_busy_deaf: assert property (O_BUSY |-> !dev_sda_oe)
		else $error("slave drove data while programming");
	chk_busy_from_stop: assert property ($rose(O_BUSY) |-> since_stop <= 8'h08)
		else $error("program cycle began without a stop");
	chk_busy_length: assert property ($fell(O_BUSY) |->
		busy_cnt >= 32'(PROG_CYCLES - 1) && busy_cnt <= 32'(PROG_CYCLES + 1))
		else $error("program cycle length off");
	chk_prog_bound: assert property (busy_cnt <= 32'(PROG_CYCLES + 1))
		else $error("program cycle overran");
	chk_wp_frame: assert property (in_frame |-> $stable(wp))
		else $error("protect level moved inside a frame");
	chk_scl_idle: assert property (!in_frame |-> scl)
		else $error("clock low outside a frame");
	chk_scl_low_span: assert property ($fell(scl) |-> scl_low_hold)
		else $error("clock low phase too short");
	chk_sda_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("slave moved data while clock high");
	chk_dev_quiet: assert property (!in_frame |-> !dev_sda_oe)
		else $error("slave drove data outside a frame");
endmodule // sep_link_chk

`default_nettype wire

// [sim/serial_eeprom_access_protocol_test.sv]
// Bench joining the EEPROM slave and the APB-driven master over the link.
`timescale 1ns/100ps
`default_nettype none

module serial_eeprom_access_protocol_test;
	localparam int PROG = 2000;
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic        err_q;
	logic [7:0]  mem [0:2047];
	int          n_errors;
	int          total_checks;

	// ========
	// Design under test
	sep_link_if link ();
	sep_eeprom_dev #(.PROG_CYCLES(PROG)) sep_eeprom_dev_i (.I_CLK(clk), .I_RST(rst),
		.LINK(link.dev), .I_SEL(3'h0), .O_BUSY(busy));
	sep_i2c_host #(.QTR_CYCLES(5)) sep_i2c_host_i (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .LINK(link.host));
	sep_link_chk #(.PROG_CYCLES(PROG)) sep_link_chk_i (.I_CLK(clk), .I_RST(rst),
		.O_BUSY(busy), .scl(link.scl), .sda(link.sda), .wp(link.wp),
		.dev_sda_oe(link.dev_sda_oe));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ========
	// Bus tasks
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_ack(input logic got, input logic exp);
		cmp_val({31'h0, got}, {31'h0, exp});
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		q = prdata;
		err_q = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// One link operation, then wait for the master to finish it.
	task automatic xb(input sep_pkg::sep_op_e op, input logic [7:0] b, input logic nk,
		output logic nak, output logic [7:0] rx);
		logic [31:0] st;
		apb(1'b1, sep_pkg::REG_CMD, {21'h0, nk, op, b}, st);
		do
		begin
			apb(1'b0, sep_pkg::REG_STATUS, 32'h0, st);
		end
		while (st[sep_pkg::STAT_BUSY_BIT] !== 1'b0);
		nak = st[sep_pkg::STAT_NOACK_BIT];
		rx = st[15:8];
	endtask

	function automatic logic [7:0] sa(input logic [10:0] a, input logic rd);
		return {sep_pkg::TYPE_CODE_DEF, a[10:8], rd};
	endfunction

	task automatic poll(input logic [10:0] a);
		logic       nak;
		logic [7:0] rx;
		int         k;
		k = 0;
		do
		begin
			xb(sep_pkg::OP_START_WR, sa(a, 1'b0), 1'b0, nak, rx);
			k++;
		end
		while (nak !== 1'b0 && k < 40);
		cmp_ack(nak, 1'b0);
		xb(sep_pkg::OP_STOP, 8'h00, 1'b0, nak, rx);
	endtask

	task automatic wr_page(input logic [10:0] a, input int n, input logic [7:0] d0,
		input logic prot);
		logic       nak;
		logic [7:0] rx;
		xb(sep_pkg::OP_START_WR, sa(a, 1'b0), 1'b0, nak, rx);
		cmp_ack(nak, 1'b0);
		xb(sep_pkg::OP_WR, a[7:0], 1'b0, nak, rx);
		cmp_ack(nak, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			xb(sep_pkg::OP_WR, d0 + 8'(i), 1'b0, nak, rx);
			cmp_ack(nak, 1'b0);
			if (!prot)
				mem[{a[10:4], a[3:0] + 4'(i)}] = d0 + 8'(i);
		end
		xb(sep_pkg::OP_STOP, 8'h00, 1'b0, nak, rx);
		xb(sep_pkg::OP_START_WR, sa(a, 1'b0), 1'b0, nak, rx);
		cmp_ack(nak, !prot);
		if (prot)
			xb(sep_pkg::OP_STOP, 8'h00, 1'b0, nak, rx);
		else
			poll(a);
	endtask

	task automatic rd(input logic [10:0] a, input int n, input logic rnd);
		logic       nak;
		logic [7:0] rx;
		if (rnd)
		begin
			xb(sep_pkg::OP_START_WR, sa(a, 1'b0), 1'b0, nak, rx);
			xb(sep_pkg::OP_WR, a[7:0], 1'b0, nak, rx);
			cmp_ack(nak, 1'b0);
		end
		xb(sep_pkg::OP_START_WR, sa(a, 1'b1), 1'b0, nak, rx);
		cmp_ack(nak, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			xb(sep_pkg::OP_RD, 8'h00, i == n - 1, nak, rx);
			cmp_val({24'h0, rx}, {24'h0, mem[a + 11'(i)]});
		end
		xb(sep_pkg::OP_STOP, 8'h00, 1'b0, nak, rx);
	endtask

	// ========
	// Scenarios
	task automatic t_regs();
		logic [31:0] q;
		apb(1'b0, sep_pkg::REG_CTRL, 32'h0, q);
		cmp_val(q, 32'h0);
		apb(1'b0, 8'h0c, 32'h0, q);
		cmp_val({q[30:0], err_q}, 32'h1);
		cmp_ack(link.wp, 1'b0);
	endtask

	task automatic t_page();
		wr_page(11'h12e, 18, 8'h30, 1'b0);
		rd(11'h120, 1, 1'b0);
		rd(11'h120, 15, 1'b1);
		rd(11'h12f, 1, 1'b0);
	endtask

	task automatic t_wrap();
		wr_page(11'h7ff, 1, 8'h9c, 1'b0);
		wr_page(11'h000, 1, 8'h63, 1'b0);
		rd(11'h7ff, 2, 1'b1);
	endtask

	task automatic t_protect();
		logic [31:0] q;
		wr_page(11'h400, 1, 8'h5a, 1'b0);
		apb(1'b1, sep_pkg::REG_CTRL, 32'h3, q);
		wr_page(11'h400, 1, 8'ha5, 1'b1);
		wr_page(11'h3ff, 1, 8'h77, 1'b0);
		rd(11'h3ff, 2, 1'b1);
		apb(1'b1, sep_pkg::REG_CTRL, 32'h1, q);
		repeat (2) @(posedge clk);
		cmp_ack(link.wp, 1'b0);
		wr_page(11'h400, 1, 8'hc3, 1'b0);
		rd(11'h400, 1, 1'b1);
	endtask

	// ========
	// Run control
	task automatic summarize();
		if (n_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		n_errors = 0;
		total_checks = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_page();
		t_wrap();
		t_protect();
		summarize();
	end

	initial
	begin
		repeat (95000) @(posedge clk);
		n_errors++;
		summarize();
	end
endmodule // serial_eeprom_access_protocol_test

`default_nettype wire

// [verilog/sep_eeprom_dev.sv]
// Two-wire serial EEPROM slave with page buffer, self-timed programming and reads.
`timescale 1ns/100ps
`default_nettype none

module sep_eeprom_dev #(
	parameter int         ADDR_W      = sep_pkg::ADDR_W_16K,
	parameter int         PROG_CYCLES = sep_pkg::PROG_CYCLES,
	parameter logic [3:0] TYPE_CODE   = sep_pkg::TYPE_CODE_DEF
) (
	input  wire logic       I_CLK,
	input  wire logic       I_RST,
	sep_link_if.dev         LINK,
	input  wire logic [2:0] I_SEL,
	output logic            O_BUSY
);

	if (!(ADDR_W == sep_pkg::ADDR_W_2K || ADDR_W == sep_pkg::ADDR_W_4K ||
	      ADDR_W == sep_pkg::ADDR_W_16K) || PROG_CYCLES < 2)
	begin : g_bad_param
		$error("Unsupported array width or program time.");
	end

	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_ADDR  = 5'h02,
		S_WORD  = 5'h04,
		S_WDATA = 5'h08,
		S_RDATA = 5'h10
	} sep_dstate_e;

	localparam logic [ADDR_W-1:0] LO8 = ADDR_W'(12'h0ff);
	localparam int PW = $clog2(PROG_CYCLES);

	logic [7:0]        mem [2**ADDR_W];
	logic [7:0]        pbuf [sep_pkg::PAGE_BYTES];
	logic [15:0]       pvalid;
	sep_dstate_e       state;
	logic [3:0]        cnt;
	logic              in_ack;
	logic              macked;
	logic              wr_seen;
	logic [7:0]        shreg;
	logic [ADDR_W-1:0] ptr;
	logic              busy;
	logic [PW-1:0]     prog_cnt;
	logic [2:0]        scl_sy;
	logic [2:0]        sda_sy;
	logic [1:0]        wp_sy;

	// ============================================================================
	// Slave address decode.
	function automatic logic addr_match(input logic [7:0] b, input logic [2:0] s);
		logic sel_ok;
		sel_ok = 1'b1;
		if (ADDR_W == sep_pkg::ADDR_W_2K)
			sel_ok = (b[3:1] == s);
		else if (ADDR_W == sep_pkg::ADDR_W_4K)
			sel_ok = (b[3:2] == s[2:1]);
		return (b[7:4] == TYPE_CODE) && sel_ok;
	endfunction

	// Upper address bits that the slave address carries on larger arrays.
	function automatic logic [ADDR_W-1:0] addr_high(input logic [7:0] b);
		logic [10:0] wide;
		wide = {b[3:1], 8'h00};
		return wide[ADDR_W-1:0];
	endfunction

	// ============================================================================
	// Line synchronisers and event detection.
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			scl_sy <= 3'h7;
			sda_sy <= 3'h7;
			wp_sy  <= 2'h0;
		end
		else
		begin
			scl_sy <= {scl_sy[1:0], LINK.scl};
			sda_sy <= {sda_sy[1:0], LINK.sda};
			wp_sy  <= {wp_sy[0], LINK.wp};
		end
	end

	wire logic sda_h     = sda_sy[1];
	wire logic scl_rise  = scl_sy[1] & ~scl_sy[2];
	wire logic scl_fall  = ~scl_sy[1] & scl_sy[2];
	wire logic start_det = scl_sy[1] & scl_sy[2] & ~sda_sy[1] & sda_sy[2];
	wire logic stop_det  = scl_sy[1] & scl_sy[2] & sda_sy[1] & ~sda_sy[2];
	wire logic active    = ~busy & ~start_det & ~stop_det & (state != S_IDLE);
	wire logic ack_edge  = active & scl_fall & (cnt == 4'h8) & ~in_ack;
	wire logic end_edge  = active & scl_fall & in_ack;
	wire logic pbuf_we   = ack_edge & (state == S_WDATA);
	wire logic protect   = wp_sy[1] &
		((ADDR_W != sep_pkg::ADDR_W_16K) || ptr[ADDR_W-1]);
	wire logic prog_go   = ~busy & stop_det & (state == S_WDATA) & wr_seen &
		~protect;
	wire logic prog_done = busy & (prog_cnt == PW'(PROG_CYCLES - 1));
	wire logic [7:0] rd_byte = mem[ptr];

	// ============================================================================
	// Self-timed program cycle.
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			busy     <= 1'b0;
			prog_cnt <= '0;
		end
		else if (prog_go)
		begin
			busy     <= 1'b1;
			prog_cnt <= '0;
		end
		else if (busy)
		begin
			prog_cnt <= prog_cnt + 1'b1;
			if (prog_done)
				busy <= 1'b0;
		end
	end

	assign O_BUSY = busy;

	// ============================================================================
	// Page buffer and array.
	always_ff @(posedge I_CLK)
	begin
		if (pbuf_we)
			pbuf[ptr[sep_pkg::PAGE_BITS-1:0]] <= shreg;
	end

	always_ff @(posedge I_CLK)
	begin
		if (prog_done)
			for (int i = 0; i < sep_pkg::PAGE_BYTES; i++)
				if (pvalid[i])
					mem[{ptr[ADDR_W-1:sep_pkg::PAGE_BITS], 4'(i)}] <= pbuf[i];
	end

	// ============================================================================
	// Protocol engine.
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			state           <= S_IDLE;
			cnt             <= 4'h0;
			in_ack          <= 1'b0;
			macked          <= 1'b0;
			wr_seen         <= 1'b0;
			shreg           <= 8'h00;
			ptr             <= '0;
			pvalid          <= 16'h0000;
			LINK.dev_sda_oe <= 1'b0;
		end
		else if (busy)
		begin
			state           <= S_IDLE;
			in_ack          <= 1'b0;
			LINK.dev_sda_oe <= 1'b0;
		end
		else if (start_det)
		begin
			state           <= S_ADDR;
			cnt             <= 4'h0;
			in_ack          <= 1'b0;
			LINK.dev_sda_oe <= 1'b0;
		end
		else if (stop_det)
		begin
			state           <= S_IDLE;
			in_ack          <= 1'b0;
			LINK.dev_sda_oe <= 1'b0;
		end
		else if (state != S_IDLE)
		begin
			if (scl_rise && in_ack)
				macked <= ~sda_h;
			else if (scl_rise && state != S_RDATA)
			begin
				shreg <= {shreg[6:0], sda_h};
				cnt   <= cnt + 4'h1;
			end
			else if (scl_rise)
				cnt <= cnt + 4'h1;
			else if (ack_edge)
			begin
				in_ack <= 1'b1;
				case (state)
					S_ADDR:
					begin
						if (addr_match(shreg, I_SEL))
						begin
							LINK.dev_sda_oe <= 1'b1;
							ptr     <= (ptr & LO8) | addr_high(shreg);
							wr_seen <= 1'b0;
							state   <= shreg[0] ? S_RDATA : S_WORD;
						end
						else
						begin
							in_ack <= 1'b0;
							state  <= S_IDLE;
						end
					end
					S_WORD:
					begin
						LINK.dev_sda_oe <= 1'b1;
						ptr    <= (ptr & ~LO8) | ADDR_W'(shreg);
						pvalid <= 16'h0000;
						state  <= S_WDATA;
					end
					S_WDATA:
					begin
						LINK.dev_sda_oe <= 1'b1;
						pvalid[ptr[sep_pkg::PAGE_BITS-1:0]] <= 1'b1;
						ptr[sep_pkg::PAGE_BITS-1:0] <=
							ptr[sep_pkg::PAGE_BITS-1:0] + 4'h1;
						wr_seen <= 1'b1;
					end
					default:
						LINK.dev_sda_oe <= 1'b0;
				endcase
			end
			else if (end_edge)
			begin
				in_ack <= 1'b0;
				cnt    <= 4'h0;
				if (state == S_RDATA && macked)
				begin
					shreg           <= rd_byte;
					LINK.dev_sda_oe <= ~rd_byte[7];
					ptr             <= ptr + 1'b1;
				end
				else
				begin
					LINK.dev_sda_oe <= 1'b0;
					if (state == S_RDATA)
						state <= S_IDLE;
				end
			end
			else if (active && scl_fall && state == S_RDATA)
			begin
				LINK.dev_sda_oe <= (cnt == 4'h8) ? 1'b0 : ~shreg[6];
				shreg           <= {shreg[6:0], 1'b0};
			end
		end
	end

endmodule // sep_eeprom_dev

`default_nettype wire

// [verilog/sep_i2c_host.sv]
// Two-wire bus master driven by byte commands through APB registers.
`timescale 1ns/100ps
`default_nettype none

module sep_i2c_host #(
	parameter int QTR_CYCLES = sep_pkg::QTR_CYCLES
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic [31:0]      O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	sep_link_if.host         LINK
);

	if (QTR_CYCLES < 2)
	begin : g_bad_param
		$error("Quarter bit period too short.");
	end

	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_START = 4'h2,
		H_BITS  = 4'h4,
		H_STOP  = 4'h8
	} sep_hstate_e;

	localparam int QW = $clog2(QTR_CYCLES);

	sep_hstate_e  state;
	logic [QW-1:0] qcnt;
	logic [1:0]    ph;
	logic [3:0]    bi;
	logic [7:0]    tx;
	logic [7:0]    rx;
	logic          is_rd;
	logic          nack;
	logic          noack;
	logic          in_frame;
	logic [1:0]    ctrl;
	logic [1:0]    sda_sy;

	// ============================================================================
	// APB slave.
	wire logic acc      = I_PSEL & I_PENABLE;
	wire logic hit_cmd  = (I_PADDR == sep_pkg::REG_CMD);
	wire logic hit_stat = (I_PADDR == sep_pkg::REG_STATUS);
	wire logic hit_ctrl = (I_PADDR == sep_pkg::REG_CTRL);
	wire logic busy     = (state != H_IDLE);
	wire logic cmd_go   = acc & I_PWRITE & hit_cmd & ~busy;
	wire logic tick     = (qcnt == QW'(QTR_CYCLES - 1));
	sep_pkg::sep_op_e op;
	assign op = sep_pkg::sep_op_e'(I_PWDATA[sep_pkg::CMD_OP_LSB +: 2]);
	wire logic [31:0] stat_word = {16'h0000, rx, 6'h00, noack, busy};
	wire logic bitval = (bi == 4'h8) ? (is_rd ? nack : 1'b1)
	                                 : (is_rd ? 1'b1 : tx[7]);

	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = acc & ~(hit_cmd | hit_stat | hit_ctrl);

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			O_PRDATA <= 32'h00000000;
		else if (I_PSEL && !I_PENABLE)
			O_PRDATA <= hit_stat ? stat_word : hit_ctrl ? {30'h0, ctrl} : 32'h00000000;
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			ctrl <= sep_pkg::CTRL_RST;
		else if (acc && I_PWRITE && hit_ctrl)
			ctrl <= I_PWDATA[sep_pkg::CTRL_WPEN_BIT:sep_pkg::CTRL_WP_BIT];
	end

	// ============================================================================
	// Line drive and sampling.
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			sda_sy        <= 2'h3;
			LINK.wp_drive <= 1'b0;
			LINK.wp_oe    <= 1'b0;
		end
		else
		begin
			sda_sy <= {sda_sy[0], LINK.sda};
			if (!in_frame)
			begin
				LINK.wp_drive <= ctrl[sep_pkg::CTRL_WP_BIT];
				LINK.wp_oe    <= ctrl[sep_pkg::CTRL_WPEN_BIT];
			end
		end
	end

	// ============================================================================
	// Bit engine: four quarter periods per bit.
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			state            <= H_IDLE;
			qcnt             <= '0;
			ph               <= 2'h0;
			bi               <= 4'h0;
			tx               <= 8'h00;
			rx               <= 8'h00;
			is_rd            <= 1'b0;
			nack             <= 1'b0;
			noack            <= 1'b0;
			in_frame         <= 1'b0;
			LINK.host_scl_oe <= 1'b0;
			LINK.host_sda_oe <= 1'b0;
		end
		else if (cmd_go)
		begin
			qcnt  <= '0;
			ph    <= 2'h0;
			bi    <= 4'h0;
			tx    <= I_PWDATA[sep_pkg::CMD_DATA_LSB +: 8];
			nack  <= I_PWDATA[sep_pkg::CMD_NACK_BIT];
			is_rd <= (op == sep_pkg::OP_RD);
			case (op)
				sep_pkg::OP_START_WR:
				begin
					state    <= H_START;
					in_frame <= 1'b1;
				end
				sep_pkg::OP_STOP:
					state <= H_STOP;
				default:
					state <= H_BITS;
			endcase
		end
		else if (busy)
		begin
			qcnt <= tick ? '0 : qcnt + 1'b1;
			if (tick)
			begin
				ph <= ph + 2'h1;
				case (state)
					H_START:
						case (ph)
							2'h0: LINK.host_sda_oe <= 1'b0;
							2'h1: LINK.host_scl_oe <= 1'b0;
							2'h2: LINK.host_sda_oe <= 1'b1;
							default:
							begin
								LINK.host_scl_oe <= 1'b1;
								state            <= H_BITS;
							end
						endcase
					H_BITS:
						case (ph)
							2'h0: LINK.host_sda_oe <= ~bitval;
							2'h1: LINK.host_scl_oe <= 1'b0;
							2'h2:
								if (bi == 4'h8)
									noack <= sda_sy[1];
								else
									rx <= {rx[6:0], sda_sy[1]};
							default:
							begin
								LINK.host_scl_oe <= 1'b1;
								tx               <= {tx[6:0], 1'b0};
								bi               <= bi + 4'h1;
								if (bi == 4'h8)
									state <= H_IDLE;
							end
						endcase
					H_STOP:
						case (ph)
							2'h0: LINK.host_sda_oe <= 1'b1;
							2'h1: LINK.host_scl_oe <= 1'b0;
							2'h2: LINK.host_sda_oe <= 1'b0;
							default:
							begin
								state    <= H_IDLE;
								in_frame <= 1'b0;
							end
						endcase
					default:
						state <= H_IDLE;
				endcase
			end
		end
	end

endmodule // sep_i2c_host

`default_nettype wire

// [verilog/sep_link_if.sv]
// Two-wire link between the EEPROM slave and the bus master, with wire resolution.
`timescale 1ns/100ps
`default_nettype none

interface sep_link_if;
	logic host_scl_oe;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic wp_drive;
	logic wp_oe;
	logic scl;
	logic sda;
	logic wp;

	// ============================================================================
	// Open-drain lines float high unless someone pulls them low.
	assign scl = ~host_scl_oe;
	assign sda = ~(host_sda_oe | dev_sda_oe);
	// An undriven protect input reads low.
	assign wp  = wp_oe & wp_drive;

	modport dev  (input scl, input sda, input wp, output dev_sda_oe);
	modport host (input sda, output host_scl_oe, output host_sda_oe,
	              output wp_drive, output wp_oe);
endinterface

`default_nettype wire

// [verilog/sep_pkg.sv]
// Shared constants and types for the serial EEPROM slave and its two-wire bus master.
// ============================================================================
// Operation
// - 2K/4K: high protect input blocks all writes
// - 16K: high protect blocks writes 400-7FF only
// - Protect input pulled low when undriven
// - Master holds protect level from start to stop
// - Byte write: address, word address, data, each acknowledged
// - Stop after write starts program; device then deaf
// - Page write takes up to sixteen acknowledged bytes
// - Page write increments only low four pointer bits
// - Low nibble wraps 1111 to 0000 in page
// - Extra page bytes overwrite earlier ones in order
// - No address acknowledge while programming, then acknowledge
// - Master polls with start and write address
// - After poll, send word address or stop first
// - Three reads, begun with direction bit one
// - Read ends with no-acknowledge then stop
// - Address counter holds last address plus one
// - Read address acknowledged, byte shifted out
// - Random read: dummy write then repeated start
// - Master acknowledge fetches next sequential byte
// - Read counter wraps over whole array
// - Slave address: type code, three bits, direction
// - Larger densities take top address bits there
// - Internal program cycle lasts at most 10 ms
`default_nettype none

package sep_pkg;

	// ============================================================================
	// Timing
	localparam int CLK_MHZ       = 100;
	localparam int PROG_TIME_MS  = 10;
	localparam int PROG_CYCLES   = PROG_TIME_MS * CLK_MHZ * 1000;
	localparam int SCL_KHZ       = 100;
	localparam int QTR_CYCLES    = (CLK_MHZ * 1000) / (SCL_KHZ * 4);

	// ============================================================================
	// Array geometry
	localparam int ADDR_W_2K     = 8;
	localparam int ADDR_W_4K     = 9;
	localparam int ADDR_W_16K    = 11;
	localparam int PAGE_BITS     = 4;
	localparam int PAGE_BYTES    = 16;
	// Arbitrary type code value; a real part uses its own.
	localparam logic [3:0] TYPE_CODE_DEF = 4'h6;

	// ============================================================================
	// Master register map
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CTRL   = 8'h08;
	localparam int CMD_DATA_LSB    = 0;
	localparam int CMD_OP_LSB      = 8;
	localparam int CMD_NACK_BIT    = 10;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_NOACK_BIT  = 1;
	localparam int STAT_RX_LSB     = 8;
	localparam int CTRL_WP_BIT     = 0;
	localparam int CTRL_WPEN_BIT   = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	typedef enum logic [1:0] {
		OP_START_WR = 2'h0,
		OP_WR       = 2'h1,
		OP_RD       = 2'h2,
		OP_STOP     = 2'h3
	} sep_op_e;

endpackage

`default_nettype wire
